// ===== tbd_top.sv
// Per-scan touch and release decision with reporting modes and timers
//
// Contract
// - Touch candidate when ticks exceed threshold plus threshold times hysteresis.
// - Release candidate when ticks fall below threshold minus hysteresis share.
// - One hysteresis percentage serves all eight buttons.
// - Debounce starts on first qualifying tick; code 1 commits on second.
// - Count qualifying samples to touch/release debounce count before deciding.
// - Debounce samples are taken once per scan.
// - Release debounce off releases on first tick below lower level.
// - Report-all mode reports every touched sensor.
// - Report-first reports earliest touch, ignores others until it releases.
// - Report-strongest reports largest signal, switching when overtaken.
// - Interrupt fires on touch, release, or both, as selected.
// - Averaging freezes once the average reaches freeze threshold.
// - Three or more frozen sensors at once start offset compensation.
// - Compensation fetches fresh offset values so idle ticks return near zero.
// - Negative counter reaching limit below negative threshold starts compensation.
// - Stuck timeout releases a held touch; new touch needs real release.
// - Stuck timeout of zero disables stuck release.
// - Strongest margin acts only in report-strongest mode.
// - Challenger wins only when exceeding current strongest by more than the margin.
// - In report-first, analog level returns idle after long-press time.
// - Long-press timer leaves status and general outputs untouched.
// - Debounce code 00 none, 01 two, 10 three, 11 four samples.
// - Hysteresis code is the percentage, 0x00 to 0x64, default 0x0A.
// - Stuck timeout code is whole seconds, zero meaning off.
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module tbd_top
    import tbd_pkg::*;
#(
    parameter int unsigned SEC_LEN = SEC_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic scan_valid_i,
    input wire logic [NSENS*TICK_W-1:0] ticks_i,
    input wire logic [NSENS*TICK_W-1:0] average_i,
    output logic [NSENS-1:0] general_outputs_o,
    output logic irq_o,
    output logic [NSENS-1:0] avg_freeze_o,
    output logic comp_start_o,
    output logic aoi_active_o,
    output logic [2:0] aoi_button_o
);

    // ========================================================
    // Helpers
    function automatic logic signed [CMP_W-1:0] sext(
        input logic [TICK_W-1:0] v);
        return $signed({{(CMP_W-TICK_W){v[TICK_W-1]}}, v});
    endfunction

    function automatic logic [CMP_W-1:0] scale4(input logic [7:0] code);
        return {4'h0, code, 2'b00};
    endfunction

    function automatic logic [CMP_W-1:0] pct_of(input logic [7:0] thr,
                                                input logic [7:0] pct);
        logic [17:0] prod;
        logic [7:0] p;
        p = (pct > PCT_MAX) ? PCT_MAX : pct;
        prod = 18'({thr, 2'b00}) * 18'(p);
        return CMP_W'(prod / 18'd100);
    endfunction

    function automatic logic [2:0] first_idx(input logic [NSENS-1:0] v);
        logic [2:0] r;
        r = 3'd0;
        for (int k = NSENS - 1; k >= 0; k--) begin
            if (v[k]) begin
                r = 3'(k);
            end
        end
        return r;
    endfunction

    // ========================================================
    // Registers
    logic [7:0] cfg_q, avg_thr_q, neg_thr_q, neg_lim_q, hyst_q;
    logic [7:0] stuck_to_q, margin_q, long_q;
    logic [7:0] thr_q [NSENS];
    logic [15:0] comp_cnt_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic [NSENS-1:0] touched_q, touched_d, stuck_q, stuck_d;
    logic [NSENS-1:0] rep_q, rep_d, freeze_q;
    logic [1:0] deb_q [NSENS];
    logic [1:0] deb_d [NSENS];
    logic [7:0] neg_q [NSENS];
    logic [7:0] neg_d [NSENS];
    logic [7:0] sec_q [NSENS];
    logic [2:0] strong_q, strong_d;
    logic [31:0] tb_q;
    logic sec_tick;
    logic [7:0] lp_q;
    logic irq_q, comp_q, aoi_act_q;
    logic [2:0] aoi_idx_q;
    logic [3:0] frozen_now, frozen_q;
    logic neg_fire;
    tbd_mode_t mode;

    assign mode = tbd_mode_t'(cfg_q[CFG_MODE_LSB +: 2]);

    // ========================================================
    // APB slave, no wait states: pready rises in the first access cycle
    logic wr_en, unmapped;
    logic [31:0] rd_mux;

    assign wr_en = psel_i & penable_i & pwrite_i & pready_q;

    always_comb begin
        unmapped = 1'b0;
        rd_mux = 32'h0000_0000;
        unique case (paddr_i)
            OFS_BUTTON_CONFIG: rd_mux = {24'h00_0000, cfg_q};
            OFS_AVG_FREEZE: rd_mux = {24'h00_0000, avg_thr_q};
            OFS_NEG_COMP_THR: rd_mux = {24'h00_0000, neg_thr_q};
            OFS_NEG_CNT_LIMIT: rd_mux = {24'h00_0000, neg_lim_q};
            OFS_HYST_PCT: rd_mux = {24'h00_0000, hyst_q};
            OFS_STUCK_TIMEOUT: rd_mux = {24'h00_0000, stuck_to_q};
            OFS_STRONG_MARGIN: rd_mux = {24'h00_0000, margin_q};
            OFS_LONG_PRESS: rd_mux = {24'h00_0000, long_q};
            OFS_THR_LO: rd_mux = {thr_q[3], thr_q[2], thr_q[1], thr_q[0]};
            OFS_THR_HI: rd_mux = {thr_q[7], thr_q[6], thr_q[5], thr_q[4]};
            OFS_STATUS: rd_mux = {8'h00, freeze_q, touched_q, rep_q};
            OFS_COMP_COUNT: rd_mux = {16'h0000, comp_cnt_q};
            default: unmapped = 1'b1;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel_i & ~penable_i;
            pslverr_q <= psel_i & ~penable_i & unmapped;
            prdata_q <= (psel_i & ~penable_i & ~pwrite_i) ? rd_mux
                                                          : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cfg_q <= RST_BUTTON_CONFIG;
            avg_thr_q <= RST_AVG_FREEZE;
            neg_thr_q <= RST_NEG_COMP_THR;
            neg_lim_q <= RST_NEG_CNT_LIMIT;
            hyst_q <= RST_HYST_PCT;
            stuck_to_q <= RST_STUCK_TIMEOUT;
            margin_q <= RST_STRONG_MARGIN;
            long_q <= RST_LONG_PRESS;
            for (int i = 0; i < NSENS; i++) begin
                thr_q[i] <= RST_TOUCH_THR;
            end
        end else if (wr_en) begin
            unique case (paddr_i)
                OFS_BUTTON_CONFIG: cfg_q <= pwdata_i[7:0];
                OFS_AVG_FREEZE: avg_thr_q <= pwdata_i[7:0];
                OFS_NEG_COMP_THR: neg_thr_q <= pwdata_i[7:0];
                OFS_NEG_CNT_LIMIT: neg_lim_q <= pwdata_i[7:0];
                OFS_HYST_PCT: hyst_q <= pwdata_i[7:0];
                OFS_STUCK_TIMEOUT: stuck_to_q <= pwdata_i[7:0];
                OFS_STRONG_MARGIN: margin_q <= pwdata_i[7:0];
                OFS_LONG_PRESS: long_q <= pwdata_i[7:0];
                OFS_THR_LO: begin
                    for (int i = 0; i < 4; i++) begin
                        thr_q[i] <= pwdata_i[8*i +: 8];
                    end
                end
                OFS_THR_HI: begin
                    for (int i = 0; i < 4; i++) begin
                        thr_q[i+4] <= pwdata_i[8*i +: 8];
                    end
                end
                default: ;
            endcase
        end
    end

    // ========================================================
    // One-second time base
    assign sec_tick = (tb_q == SEC_LEN - 1);

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            tb_q <= 32'h0000_0000;
        end else begin
            tb_q <= sec_tick ? 32'h0000_0000 : tb_q + 32'h0000_0001;
        end
    end

    // ========================================================
    // Per-sensor touch and release decision
    always_comb begin
        logic signed [CMP_W-1:0] tk, hi, lo, neg_lvl;
        logic [CMP_W-1:0] h;
        logic [2:0] need_t, need_r, cnt1;
        tk = '0;
        hi = '0;
        lo = '0;
        h = '0;
        need_t = 3'd0;
        need_r = 3'd0;
        cnt1 = 3'd0;
        neg_fire = 1'b0;
        neg_lvl = -$signed(scale4(neg_thr_q));
        touched_d = touched_q;
        stuck_d = stuck_q;
        for (int i = 0; i < NSENS; i++) begin
            deb_d[i] = deb_q[i];
            neg_d[i] = neg_q[i];
            tk = sext(ticks_i[i*TICK_W +: TICK_W]);
            h = pct_of(thr_q[i], hyst_q);
            hi = $signed(scale4(thr_q[i]) + h);
            lo = $signed(scale4(thr_q[i]) - h);
            need_t = {1'b0, cfg_q[CFG_TDEB_LSB +: 2]} + 3'd1;
            need_r = {1'b0, cfg_q[CFG_RDEB_LSB +: 2]} + 3'd1;
            cnt1 = {1'b0, deb_q[i]} + 3'd1;
            if (touched_q[i] && stuck_to_q != 8'h00 &&
                sec_q[i] >= stuck_to_q) begin
                touched_d[i] = 1'b0;
                stuck_d[i] = 1'b1;
                deb_d[i] = 2'd0;
            end else if (scan_valid_i) begin
                if (stuck_q[i]) begin
                    if (tk < lo) begin
                        stuck_d[i] = 1'b0;
                    end
                end else if (touched_q[i]) begin
                    if (tk < lo) begin
                        if (cnt1 >= need_r) begin
                            touched_d[i] = 1'b0;
                            deb_d[i] = 2'd0;
                        end else begin
                            deb_d[i] = cnt1[1:0];
                        end
                    end else begin
                        deb_d[i] = 2'd0;
                    end
                end else if (tk > hi) begin
                    if (cnt1 >= need_t) begin
                        touched_d[i] = 1'b1;
                        deb_d[i] = 2'd0;
                    end else begin
                        deb_d[i] = cnt1[1:0];
                    end
                end else begin
                    deb_d[i] = 2'd0;
                end
                if (tk < neg_lvl) begin
                    neg_d[i] = (neg_q[i] == 8'hFF) ? neg_q[i]
                                                   : neg_q[i] + 8'd1;
                    if (neg_d[i] >= neg_lim_q) begin
                        neg_fire = 1'b1;
                    end
                end else begin
                    neg_d[i] = 8'd0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            touched_q <= '0;
            stuck_q <= '0;
            for (int i = 0; i < NSENS; i++) begin
                deb_q[i] <= 2'd0;
                neg_q[i] <= 8'd0;
            end
        end else begin
            touched_q <= touched_d;
            stuck_q <= stuck_d;
            for (int i = 0; i < NSENS; i++) begin
                deb_q[i] <= deb_d[i];
                // Compensation restarts every negative count
                neg_q[i] <= comp_q ? 8'd0 : neg_d[i];
            end
        end
    end

    // Hold time of each touch, saturating at 255 s
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NSENS; i++) begin
                sec_q[i] <= 8'd0;
            end
        end else begin
            for (int i = 0; i < NSENS; i++) begin
                if (touched_d[i] && !touched_q[i]) begin
                    sec_q[i] <= 8'd0;
                end else if (touched_q[i] && sec_tick &&
                             sec_q[i] != 8'hFF) begin
                    sec_q[i] <= sec_q[i] + 8'd1;
                end
            end
        end
    end

    // ========================================================
    // Reporting modes
    always_comb begin
        logic signed [CMP_W-1:0] best_v, cur_v, cand_v;
        logic [2:0] best;
        best = 3'd0;
        best_v = '0;
        cand_v = '0;
        rep_d = '0;
        strong_d = strong_q;
        cur_v = sext(ticks_i[strong_q*TICK_W +: TICK_W]);
        for (int i = 0; i < NSENS; i++) begin
            cand_v = sext(ticks_i[i*TICK_W +: TICK_W]);
            if (touched_d[i] && (rep_d == '0 || cand_v > best_v)) begin
                best = 3'(i);
                best_v = cand_v;
                rep_d = '0;
                rep_d[i] = 1'b1;
            end
        end
        rep_d = '0;
        unique case (mode)
            TBD_MODE_FIRST: begin
                if ((rep_q & touched_d) != '0) begin
                    rep_d = rep_q;
                end else if (rep_q == '0 &&
                             (touched_d & ~touched_q) != '0) begin
                    rep_d[first_idx(touched_d & ~touched_q)] = 1'b1;
                end
            end
            TBD_MODE_STRONG: begin
                if ((rep_q & touched_d) != '0) begin
                    // Margin only damps switching away from the holder
                    if (best_v > cur_v + $signed({6'h00, margin_q})) begin
                        strong_d = best;
                    end
                end else if (touched_d != '0) begin
                    strong_d = best;
                end
                if (touched_d != '0) begin
                    rep_d[strong_d] = 1'b1;
                end
            end
            default: rep_d = touched_d;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rep_q <= '0;
            strong_q <= 3'd0;
            irq_q <= 1'b0;
        end else begin
            rep_q <= rep_d;
            strong_q <= strong_d;
            irq_q <= (cfg_q[CFG_IRQ_TOUCH] && (rep_d & ~rep_q) != '0) ||
                     (cfg_q[CFG_IRQ_REL] && (rep_q & ~rep_d) != '0);
        end
    end

    // ========================================================
    // Averaging freeze and offset compensation triggers
    always_comb begin
        frozen_now = 4'd0;
        for (int i = 0; i < NSENS; i++) begin
            if (sext(average_i[i*TICK_W +: TICK_W]) >=
                $signed(scale4(avg_thr_q))) begin
                frozen_now = frozen_now + 4'd1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            freeze_q <= '0;
            frozen_q <= 4'd0;
            comp_q <= 1'b0;
            comp_cnt_q <= 16'h0000;
        end else begin
            for (int i = 0; i < NSENS; i++) begin
                freeze_q[i] <= sext(average_i[i*TICK_W +: TICK_W]) >=
                               $signed(scale4(avg_thr_q));
            end
            if (scan_valid_i) begin
                frozen_q <= frozen_now;
            end
            // Edge on the count so a long touch does not retrigger
            comp_q <= (scan_valid_i && frozen_now >= 4'd3 &&
                       frozen_q < 4'd3) || neg_fire;
            if (comp_q) begin
                comp_cnt_q <= comp_cnt_q + 16'h0001;
            end
        end
    end

    // ========================================================
    // Analog level selection with long-press cut-off
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            lp_q <= 8'd0;
            aoi_act_q <= 1'b0;
            aoi_idx_q <= 3'd0;
        end else begin
            if (rep_d != rep_q) begin
                lp_q <= 8'd0;
            end else if (rep_q != '0 && sec_tick && lp_q != 8'hFF) begin
                lp_q <= lp_q + 8'd1;
            end
            aoi_idx_q <= first_idx(rep_d);
            aoi_act_q <= rep_d != '0 &&
                         !(mode == TBD_MODE_FIRST && long_q != 8'h00 &&
                           rep_d == rep_q && lp_q >= long_q);
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign general_outputs_o = rep_q;
    assign irq_o = irq_q;
    assign avg_freeze_o = freeze_q;
    assign comp_start_o = comp_q;
    assign aoi_active_o = aoi_act_q;
    assign aoi_button_o = aoi_idx_q;

endmodule

// ===== tbd_pkg.sv
// Constants, register map and types of the touch button decision block
package tbd_pkg;

    // ========================================================
    // Sizes
    localparam int unsigned NSENS = 8;
    localparam int unsigned TICK_W = 12;
    localparam int unsigned CMP_W = 14;

    // ========================================================
    // Register byte offsets
    localparam logic [11:0] OFS_BUTTON_CONFIG = 12'h000;
    localparam logic [11:0] OFS_AVG_FREEZE = 12'h004;
    localparam logic [11:0] OFS_NEG_COMP_THR = 12'h008;
    localparam logic [11:0] OFS_NEG_CNT_LIMIT = 12'h00C;
    localparam logic [11:0] OFS_HYST_PCT = 12'h010;
    localparam logic [11:0] OFS_STUCK_TIMEOUT = 12'h014;
    localparam logic [11:0] OFS_STRONG_MARGIN = 12'h018;
    localparam logic [11:0] OFS_LONG_PRESS = 12'h01C;
    localparam logic [11:0] OFS_THR_LO = 12'h020;
    localparam logic [11:0] OFS_THR_HI = 12'h024;
    localparam logic [11:0] OFS_STATUS = 12'h028;
    localparam logic [11:0] OFS_COMP_COUNT = 12'h02C;

    // ========================================================
    // Field positions of button_config
    localparam int unsigned CFG_TDEB_LSB = 0;
    localparam int unsigned CFG_RDEB_LSB = 2;
    localparam int unsigned CFG_MODE_LSB = 4;
    localparam int unsigned CFG_IRQ_TOUCH = 6;
    localparam int unsigned CFG_IRQ_REL = 7;

    // ========================================================
    // Reset values and hysteresis percentage limit
    localparam logic [7:0] RST_BUTTON_CONFIG = 8'h00;
    localparam logic [7:0] RST_AVG_FREEZE = 8'h50;
    localparam logic [7:0] RST_NEG_COMP_THR = 8'h50;
    localparam logic [7:0] RST_NEG_CNT_LIMIT = 8'h01;
    localparam logic [7:0] RST_HYST_PCT = 8'h0A;
    localparam logic [7:0] RST_STUCK_TIMEOUT = 8'h00;
    localparam logic [7:0] RST_STRONG_MARGIN = 8'h80;
    localparam logic [7:0] RST_LONG_PRESS = 8'h00;
    localparam logic [7:0] RST_TOUCH_THR = 8'h40;
    localparam logic [7:0] PCT_MAX = 8'h64;

    // ========================================================
    // Timing: one-second time base at a 100 ns clock
    localparam longint unsigned ONE_SECOND_NS = 1_000_000_000;
    localparam longint unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SEC_CYCLES = int'(ONE_SECOND_NS / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        TBD_MODE_ALL = 2'b00,
        TBD_MODE_FIRST = 2'b01,
        TBD_MODE_STRONG = 2'b10
    } tbd_mode_t;

endpackage

// ===== tbd_props.sv
// Port checker for the touch button decision block
`timescale 1ns/1ns
module tbd_props
    import tbd_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [NSENS-1:0] general_outputs_o,
    input wire logic irq_o,
    input wire logic comp_start_o,
    input wire logic aoi_active_o,
    input wire logic [2:0] aoi_button_o
);
    // ========================================================
    // Properties
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    a_ready_in_access: assert property (pready_o |->
        psel_i && penable_i && !$past(penable_i))
        else $error("ready outside access");
    a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
        else $error("read data outside access");
    a_err_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_irq_one_cycle: assert property (irq_o |=> !irq_o)
        else $error("irq pulse too long");
    a_irq_on_change: assert property (irq_o |->
        general_outputs_o != $past(general_outputs_o))
        else $error("irq without report change");
    a_comp_one_cycle: assert property (comp_start_o |=> !comp_start_o)
        else $error("comp pulse too long");
    a_aoi_shows_btn: assert property (aoi_active_o |->
        general_outputs_o[aoi_button_o])
        else $error("aoi shows unreported button");
endmodule

bind tbd_top tbd_props tbd_props_i (.clk_sys_i, .rst_n_i, .psel_i,
    .penable_i, .prdata_o, .pready_o, .pslverr_o, .general_outputs_o,
    .irq_o, .comp_start_o, .aoi_active_o, .aoi_button_o);

// ===== tbd_host.sv
// APB host model reaching the block's registers
`timescale 1ns/1ns
module tbd_host (
    input wire logic clk_sys_i,
    output logic psel_o = 1'b0,
    output logic penable_o = 1'b0,
    output logic pwrite_o = 1'b0,
    output logic [11:0] paddr_o = 12'h000,
    output logic [31:0] pwdata_o = 32'h0000_0000,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i
);
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge clk_sys_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_sys_i);
        penable_o <= 1'b1;
        do @(posedge clk_sys_i); while (pready_i !== 1'b1);
        q = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // Released lines flip so stale values cannot pass
        paddr_o <= ~a;
        pwdata_o <= ~d;
    endtask
endmodule

// ===== tbd_top_tb.sv
// Self-checking bench of the touch button decision block
`timescale 1ns/1ns
module tbd_top_tb;
    import tbd_pkg::*;
    localparam int SEC = 20;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic scan_v = 1'b0;
    logic [95:0] ticks = '0;
    logic [95:0] avg = '0;
    logic psel, penable, pwrite, pready, pslverr, irq, comp, aoa;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rq, lf = 32'h0000_b8af;
    logic [7:0] go, frz;
    logic [2:0] aob;
    logic re;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int hi, lo, cfgv, n, st[2], cn[2], q[$];
    logic [11:0] ra[10] = '{OFS_BUTTON_CONFIG, OFS_AVG_FREEZE,
        OFS_NEG_COMP_THR, OFS_NEG_CNT_LIMIT, OFS_HYST_PCT,
        OFS_STUCK_TIMEOUT, OFS_STRONG_MARGIN, OFS_LONG_PRESS,
        OFS_THR_LO, OFS_THR_HI};
    logic [31:0] rv[10] = '{32'(RST_BUTTON_CONFIG), 32'(RST_AVG_FREEZE),
        32'(RST_NEG_COMP_THR), 32'(RST_NEG_CNT_LIMIT), 32'(RST_HYST_PCT),
        32'(RST_STUCK_TIMEOUT), 32'(RST_STRONG_MARGIN), 32'(RST_LONG_PRESS),
        {4{RST_TOUCH_THR}}, {4{RST_TOUCH_THR}}};
    bit use_m = 1'b1;

    tbd_host tbd_host_i (.clk_sys_i(clk_sys), .psel_o(psel),
        .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
        .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
        .pslverr_i(pslverr));
    tbd_top #(.SEC_LEN(SEC)) tbd_top_i (.clk_sys_i(clk_sys),
        .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .scan_valid_i(scan_v), .ticks_i(ticks), .average_i(avg),
        .general_outputs_o(go), .irq_o(irq), .avg_freeze_o(frz),
        .comp_start_o(comp), .aoi_active_o(aoa), .aoi_button_o(aob));

    // ========================================================
    // Clock, timeout and shared tasks
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > 20000) begin
            err_count++;
            test_done();
        end
    end
    function automatic int rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return int'(lf % 128) - 64;
    endfunction
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, x);
        tests_run++;
        if (s !== x) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        tbd_host_i.xfer(1'b1, a, d, rq, re);
    endtask
    task automatic mscan(input int t0, input int t1);
        int t, pv, nw;
        pv = st[0] | (st[1] << 1);
        for (int i = 0; i < 2; i++) begin
            t = i ? t1 : t0;
            if (st[i] ? t < lo : t > hi) begin
                cn[i]++;
                if (cn[i] > (st[i] ? (cfgv >> 2) & 3 : cfgv & 3)) begin
                    st[i] = !st[i];
                    cn[i] = 0;
                end
            end else
                cn[i] = 0;
        end
        nw = st[0] | (st[1] << 1);
        chk("go", 32'(go), 32'(nw));
        chk("irq", 32'(irq), 32'(((nw & ~pv) != 0 && cfgv[6]) ||
            ((pv & ~nw) != 0 && cfgv[7])));
    endtask
    task automatic scan(input int t0, input int t1);
        logic [95:0] tv;
        for (int i = 2; i < 8; i++)
            tv[12*i +: 12] = 12'(rnd());
        tv[11:0] = 12'(t0);
        tv[23:12] = 12'(t1);
        @(posedge clk_sys);
        scan_v <= 1'b1;
        ticks <= tv;
        @(posedge clk_sys);
        scan_v <= 1'b0;
        @(negedge clk_sys);
        if (use_m)
            mscan(t0, t1);
    endtask

    // ========================================================
    // Main sequence
    initial begin
        hi = 4 * RST_TOUCH_THR;
        lo = hi - hi * RST_HYST_PCT / 100;
        hi = 2 * hi - lo;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            tbd_host_i.xfer(1'b0, ra[i], 32'h0, rq, re);
            chk("reset value", rq, rv[i]);
        end
        tbd_host_i.xfer(1'b0, 12'h030, 32'h0, rq, re);
        chk("unmapped", {rq[30:0], re}, 32'h0000_0001);
        n = rnd() & 255;
        wr(OFS_LONG_PRESS, n);
        tbd_host_i.xfer(1'b0, OFS_LONG_PRESS, 32'h0, rq, re);
        chk("readback", rq, n);
        wr(OFS_LONG_PRESS, 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            cfgv = k | (k << 2) | (k << 6);
            wr(OFS_BUTTON_CONFIG, cfgv);
            q = {};
            repeat (k) q.push_back(hi + 1);
            q.push_back(hi);
            repeat (k + 1) q.push_back(hi + 1);
            q.push_back(lo);
            repeat (k + 1) q.push_back(lo - 1);
            foreach (q[j]) scan(q[j], 300);
        end
        use_m = 1'b0;
        wr(OFS_BUTTON_CONFIG, 32'h0000_0010);
        scan(0, 0);
        scan(300, 0);
        scan(300, 400);
        chk("first", 32'(go), 32'h0000_0001);
        wr(OFS_BUTTON_CONFIG, 32'h0000_0020);
        scan(300, 428);
        chk("margin", 32'(go), 32'h0000_0001);
        scan(300, 429);
        chk("strong", 32'(go), 32'h0000_0002);
        wr(OFS_BUTTON_CONFIG, 32'h0000_0000);
        scan(300, 429);
        chk("all", 32'(go), 32'h0000_0003);
        scan(0, 0);
        wr(OFS_STUCK_TIMEOUT, 32'h0000_0001);
        scan(300, 0);
        for (n = 0; n < 3 * SEC && go !== 8'h00; n++) @(negedge clk_sys);
        chk("stuck", 32'(go), 32'h0000_0000);
        scan(300, 0);
        chk("held", 32'(go), 32'h0000_0000);
        scan(0, 0);
        wr(OFS_STUCK_TIMEOUT, 32'h0000_0000);
        scan(300, 0);
        chk("retouch", 32'(go), 32'h0000_0001);
        repeat (3 * SEC) @(negedge clk_sys);
        chk("no stuck", 32'(go), 32'h0000_0001);
        wr(OFS_BUTTON_CONFIG, 32'h0000_0010);
        scan(0, 0);
        wr(OFS_LONG_PRESS, 32'h0000_0001);
        scan(300, 0);
        chk("aoi on", 32'({aob, aoa}), 32'h0000_0001);
        for (n = 0; n < 3 * SEC && aoa !== 1'b0; n++) @(negedge clk_sys);
        chk("aoi off", 32'({aob, aoa, go}), 32'h0000_0001);
        wr(OFS_NEG_CNT_LIMIT, 32'h0000_0001);
        scan(-321, 0);
        for (n = 0; n < 4 && comp !== 1'b1; n++) @(negedge clk_sys);
        chk("neg comp", 32'(comp), 32'h0000_0001);
        @(posedge clk_sys);
        avg <= 96'({3{12'h140}});
        repeat (3) @(negedge clk_sys);
        chk("freeze", 32'(frz), 32'h0000_0007);
        scan(0, 0);
        tbd_host_i.xfer(1'b0, OFS_COMP_COUNT, 32'h0, rq, re);
        chk("comp count", rq, 32'h0000_0002);
        test_done();
    end
endmodule
